/* verilog/hbp_pkg.sv */
// Shared constants and types for the host bus command port
package hbp_pkg;
  localparam logic [7:0]  CMD_FONT_BASE   = 8'h5c;
  localparam logic [7:0]  CMD_CURSOR_DIR  = 8'h4c;
  localparam logic [7:0]  CMD_CURSOR_ADDR = 8'h46;
  localparam logic [7:0]  CMD_MEM_WRITE   = 8'h42;
  localparam logic [7:0]  CMD_MEM_READ    = 8'h43;
  localparam logic [7:0]  CMD_CURSOR_READ = 8'h47;
  localparam logic [15:0] FONT_BASE_RST   = 16'h0000;
  localparam logic [15:0] CURSOR_RST      = 16'h0000;
  localparam logic [2:0]  STRAP_STYLE_LSB = 3'h2;
  localparam int          MEM_DEPTH       = 256;
  localparam int          MEM_AW          = 8;
  localparam logic [7:0]  FONT1_LO        = 8'h80;
  localparam logic [7:0]  FONT1_HI        = 8'h9f;
  localparam logic [7:0]  FONT2_LO        = 8'he0;
  localparam int          ROW_SHIFT_SHORT = 3;
  localparam int          ROW_SHIFT_TALL  = 4;
  localparam int          STROBE_CYCLES   = 2;

  typedef enum logic [1:0]
  {
    HBP_STYLE_GENERIC = 2'b00,
    HBP_STYLE_ENABLE  = 2'b01,
    HBP_STYLE_LDS     = 2'b10
  } hbp_style_t;

  typedef enum logic [1:0]
  {
    HBP_OP_NONE  = 2'b00,
    HBP_OP_READ  = 2'b01,
    HBP_OP_DATA  = 2'b10,
    HBP_OP_CMD   = 2'b11
  } hbp_op_t;
endpackage : hbp_pkg

/* verilog/hbp_if.sv */
// Parallel bus between the host end and the device end
`timescale 1ns/10ps
interface hbp_if;
  logic       cmd_data_select;
  logic       rd_n;
  logic       wr_n;
  logic       low_byte_strobe_n;
  logic [4:0] config_strap_pins;
  logic [7:0] host_d_o;
  logic       host_d_oe_n;
  logic [7:0] dev_d_o;
  logic       dev_d_oe_n;
  logic [7:0] d_bus;

  // Wired data bus; both low enables would be a bus fight
  assign d_bus = !dev_d_oe_n ? dev_d_o : (!host_d_oe_n ? host_d_o : 8'hff);

  modport host
  (
    output cmd_data_select, rd_n, wr_n, low_byte_strobe_n, config_strap_pins, host_d_o, host_d_oe_n,
    input  d_bus
  );
  modport dev
  (
    input  cmd_data_select, rd_n, wr_n, low_byte_strobe_n, config_strap_pins, d_bus,
    output dev_d_o, dev_d_oe_n
  );
endinterface : hbp_if

/* verilog/hbp_buf2.sv */
// Two-entry valid/ready buffer
`timescale 1ns/10ps
module hbp_buf2
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] in_data_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  output logic [8:0]      out_data_o,
  output logic            out_valid_o,
  input  wire logic       out_ready_i
);
  logic [8:0] mem_r [2];
  logic       wp_r;
  logic       rp_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wp_r] <= in_data_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : hbp_buf2

/* verilog/hbp_dev.sv */
// Device end: strobe decode, command sequencer, cursor and font RAM mapping
// Operation
// R1: Straps pick generic, enable or lower-strobe style
// R2: Host wires select to address bit zero
// R3: Generic style read, data write, command write
// R4: Enable style decode with enable high
// R5: Lower-strobe style decode with strobe low
// R6: 5Ch loads font base, low then high
// R7: 4Ch makes cursor step upward; code sets cursor_dir_right_o, stepping right by +1 per stored byte
// R8: 46h loads cursor, low then high byte
// R9: 42h stores bytes at cursor, advancing
// R10: Codes 80-9F, E0-FF use font RAM
// R11: Without font ROM all codes use font RAM
// R12: Font RAM use implies one bit per pixel
// R13: Graphics-only needs no font pattern load
// R14: Fetch address is base plus shifted code plus row
// R15: No valid strobe means no transfer, bus released
`timescale 1ns/10ps
module hbp_dev
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  hbp_if.dev               bus,
  input  wire logic        font_rom_off_i,
  input  wire logic        tall_font_i,
  input  wire logic [7:0]  char_code_i,
  input  wire logic [3:0]  row_sel_i,
  output logic             use_font_ram_o,
  output logic [15:0]      font_fetch_addr_o,
  output logic             one_bpp_only_o,
  output logic [15:0]      font_base_o,
  output logic [15:0]      cursor_o,
  output logic             cursor_dir_right_o,
  output logic             wr_valid_o,
  output logic [15:0]      wr_addr_o,
  output logic [7:0]       wr_data_o,
  input  wire logic        wr_ready_i
);
  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every bus pin
  logic [16:0] pin_s1_r;
  logic [16:0] pin_s2_r;
  logic [16:0] pin_raw;
  assign pin_raw = {bus.config_strap_pins, bus.cmd_data_select, bus.rd_n, bus.wr_n,
                    bus.low_byte_strobe_n, bus.d_bus};
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_r <= 17'h1f0ff;
      pin_s2_r <= 17'h1f0ff;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end
  logic [2:0]  strap;
  logic        sel;
  logic        rd_n;
  logic        wr_n;
  logic        lds_n;
  logic [7:0]  din;
  assign strap = pin_s2_r[16:14];
  assign sel   = pin_s2_r[11];
  assign rd_n  = pin_s2_r[10];
  assign wr_n  = pin_s2_r[9];
  assign lds_n = pin_s2_r[8];
  assign din   = pin_s2_r[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode per bus style
  hbp_pkg::hbp_style_t style;
  hbp_pkg::hbp_op_t    op;
  hbp_pkg::hbp_op_t    op_prev_r;
  logic                act;
  logic                take;
  always_comb
  begin
    case (strap[1:0])                                               // R1
      2'b01:   style = hbp_pkg::HBP_STYLE_ENABLE;
      2'b10:   style = hbp_pkg::HBP_STYLE_LDS;
      default: style = hbp_pkg::HBP_STYLE_GENERIC;
    endcase
  end
  // Enable and lower-strobe styles share one decode; rd_n carries direction (high = read)
  always_comb
  begin
    op  = hbp_pkg::HBP_OP_NONE;                                     // R15
    act = 1'b0;
    case (style)
      hbp_pkg::HBP_STYLE_GENERIC:
      begin
        if (sel && !rd_n && wr_n)                                   // R3
          op = hbp_pkg::HBP_OP_READ;
        else if (rd_n && !wr_n)
          op = sel ? hbp_pkg::HBP_OP_CMD : hbp_pkg::HBP_OP_DATA;
      end
      default:
      begin
        act = (style == hbp_pkg::HBP_STYLE_ENABLE) ? wr_n : !lds_n;  // R4 R5
        if (act && sel && rd_n)
          op = hbp_pkg::HBP_OP_READ;
        else if (act && !rd_n)
          op = sel ? hbp_pkg::HBP_OP_CMD : hbp_pkg::HBP_OP_DATA;
      end
    endcase
  end
  // Act once per strobe, on its leading edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      op_prev_r <= hbp_pkg::HBP_OP_NONE;
    else
      op_prev_r <= op;
  end
  assign take = (op != hbp_pkg::HBP_OP_NONE) && (op != op_prev_r);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  typedef enum logic [1:0]
  {
    HBP_ST_IDLE  = 2'b00,
    HBP_ST_BASE  = 2'b01,
    HBP_ST_CSR   = 2'b10,
    HBP_ST_WRITE = 2'b11
  } hbp_dev_st_t;
  hbp_dev_st_t st_r;
  logic        byte_idx_r;
  logic [7:0]  last_cmd_r;
  logic        rd_hi_r;
  logic        buf_in_ready;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r       <= HBP_ST_IDLE;
      byte_idx_r <= 1'b0;
      last_cmd_r <= 8'h00;
    end
    else if (take && op == hbp_pkg::HBP_OP_CMD)
    begin
      byte_idx_r <= 1'b0;
      last_cmd_r <= din;
      case (din)
        hbp_pkg::CMD_FONT_BASE:   st_r <= HBP_ST_BASE;              // R6
        hbp_pkg::CMD_CURSOR_ADDR: st_r <= HBP_ST_CSR;               // R8
        hbp_pkg::CMD_MEM_WRITE:   st_r <= HBP_ST_WRITE;             // R9
        default:                  st_r <= HBP_ST_IDLE;
      endcase
    end
    else if (take && op == hbp_pkg::HBP_OP_DATA)
      byte_idx_r <= ~byte_idx_r;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cursor_dir_right_o <= 1'b0;
    else if (take && op == hbp_pkg::HBP_OP_CMD && din == hbp_pkg::CMD_CURSOR_DIR)
      cursor_dir_right_o <= 1'b1;                                   // R7
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      font_base_o <= hbp_pkg::FONT_BASE_RST;
    else if (take && op == hbp_pkg::HBP_OP_DATA && st_r == HBP_ST_BASE)
    begin
      if (!byte_idx_r)
        font_base_o[7:0] <= din;                                    // R6
      else
        font_base_o[15:8] <= din;
    end
  end

  // Stored bytes must not be lost while the sink stalls
  logic store;
  assign store = take && op == hbp_pkg::HBP_OP_DATA && st_r == HBP_ST_WRITE && buf_in_ready;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cursor_o <= hbp_pkg::CURSOR_RST;
    else if (take && op == hbp_pkg::HBP_OP_DATA && st_r == HBP_ST_CSR)
    begin
      if (!byte_idx_r)
        cursor_o[7:0] <= din;                                       // R8
      else
        cursor_o[15:8] <= din;
    end
    else if (store && cursor_dir_right_o)
      cursor_o <= cursor_o + 16'h0001;                              // R9
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path through the two-entry buffer; a full buffer drops the byte
  logic [8:0] buf_out;
  hbp_buf2 u_buf
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({1'b0, din}),
    .in_valid_i  (store),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_out),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i)
  );
  logic [15:0] addr_q_r [2];
  logic        aw_r;
  logic        ar_r;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_r <= 1'b0;
      ar_r <= 1'b0;
    end
    else
    begin
      if (store)
        aw_r <= ~aw_r;
      if (wr_valid_o && wr_ready_i)
        ar_r <= ~ar_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (store)
      addr_q_r[aw_r] <= cursor_o;
  end
  assign wr_addr_o = addr_q_r[ar_r];
  assign wr_data_o = buf_out[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read answers: cursor bytes after a cursor-read, else the byte at the write buffer output (wr_data_o)
  logic [7:0] rd_data_r;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_data_r <= 8'h00;
      rd_hi_r   <= 1'b0;
    end
    else if (take && op == hbp_pkg::HBP_OP_READ)
    begin
      rd_hi_r   <= ~rd_hi_r;
      rd_data_r <= (last_cmd_r == hbp_pkg::CMD_CURSOR_READ) ?
                   (rd_hi_r ? cursor_o[15:8] : cursor_o[7:0]) : wr_data_o;
    end
  end
  assign bus.dev_d_o    = rd_data_r;
  assign bus.dev_d_oe_n = (op != hbp_pkg::HBP_OP_READ);             // R15

  ////////////////////////////////////////////////////////////////////////////
  // Font RAM mapping
  logic in_region;
  assign in_region = (char_code_i >= hbp_pkg::FONT1_LO && char_code_i <= hbp_pkg::FONT1_HI) ||
                     (char_code_i >= hbp_pkg::FONT2_LO);                     // R10
  assign use_font_ram_o = font_rom_off_i || in_region;                       // R11
  assign one_bpp_only_o = use_font_ram_o;                                    // R12
  always_comb
  begin
    if (tall_font_i)                                                         // R14
      font_fetch_addr_o = font_base_o + ({8'h00, char_code_i} << hbp_pkg::ROW_SHIFT_TALL)
                          + {12'h000, row_sel_i};
    else
      font_fetch_addr_o = font_base_o + ({8'h00, char_code_i} << hbp_pkg::ROW_SHIFT_SHORT)
                          + {13'h0, row_sel_i[2:0]};
  end
endmodule : hbp_dev

/* verilog/hbp_host.sv */
// Host end: turns user requests into strobe cycles in the strapped style
`timescale 1ns/10ps
module hbp_host
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  hbp_if.host              bus,
  input  wire logic [1:0]  style_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_op_i,
  input  wire logic [7:0]  req_data_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_data_o
);
  typedef enum logic [1:0]
  {
    HBH_ST_IDLE = 2'b00,
    HBH_ST_SETUP = 2'b01,
    HBH_ST_STROBE = 2'b10,
    HBH_ST_HOLD = 2'b11
  } hbp_host_st_t;

  hbp_host_st_t st_r;
  logic [1:0] op_r;
  logic [7:0] data_r;
  logic [3:0] cnt_r;
  logic       strobe_on;

  assign req_ready_o = (st_r == HBH_ST_IDLE);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r   <= HBH_ST_IDLE;
      op_r   <= 2'b00;
      data_r <= 8'h00;
      cnt_r  <= 4'h0;
    end
    else
    begin
      case (st_r)
        HBH_ST_IDLE:
          if (req_valid_i && req_op_i != 2'b00)
          begin
            op_r   <= req_op_i;
            data_r <= req_data_i;
            st_r   <= HBH_ST_SETUP;
          end
        HBH_ST_SETUP:
        begin
          cnt_r <= 4'h0;
          st_r  <= HBH_ST_STROBE;
        end
        // Strobe must outlast the device's two-flop synchroniser
        HBH_ST_STROBE:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(hbp_pkg::STROBE_CYCLES + 2))
            st_r <= HBH_ST_HOLD;
        end
        HBH_ST_HOLD:    st_r <= HBH_ST_IDLE;
        default:        st_r <= HBH_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
    end
    else
    begin
      rsp_valid_o <= (st_r == HBH_ST_STROBE) && (cnt_r == 4'(hbp_pkg::STROBE_CYCLES + 2)) && (op_r == 2'b01);
      if ((st_r == HBH_ST_STROBE) && (op_r == 2'b01))
        rsp_data_o <= bus.d_bus;
    end
  end

  assign strobe_on = (st_r == HBH_ST_STROBE);
  logic is_rd;

  assign is_rd = (op_r == 2'b01);

  // Select is address bit zero: high for command and read
  assign bus.cmd_data_select   = (st_r != HBH_ST_IDLE) && (op_r != 2'b10);  // R2
  assign bus.config_strap_pins = {1'b0, style_i, 2'b00};                    // R1

  always_comb
  begin
    case (style_i)
      2'b01:                                                                // R4
      begin
        bus.rd_n              = is_rd;
        bus.wr_n              = strobe_on;
        bus.low_byte_strobe_n = 1'b1;
      end
      2'b10:                                                                // R5
      begin
        bus.rd_n              = is_rd;
        bus.wr_n              = 1'b1;
        bus.low_byte_strobe_n = !strobe_on;
      end
      default:                                                              // R3
      begin
        bus.rd_n              = !(strobe_on && is_rd);
        bus.wr_n              = !(strobe_on && !is_rd);
        bus.low_byte_strobe_n = 1'b1;
      end
    endcase
  end

  assign bus.host_d_o    = data_r;
  assign bus.host_d_oe_n = (st_r == HBH_ST_IDLE) || is_rd;                  // R15
endmodule : hbp_host

/* dv/hbp_monitor.sv */
// Interface checker for the host bus command port
`timescale 1ns/10ps
module hbp_monitor
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cmd_data_select,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       low_byte_strobe_n,
  input  wire logic [4:0] config_strap_pins,
  input  wire logic [7:0] host_d_o,
  input  wire logic       host_d_oe_n,
  input  wire logic       dev_d_oe_n
);
  logic [1:0] sty;
  logic       rd_dec;
  logic [2:0] quiet_r;
  logic [2:0] quiet_nxt;

  // Style code 3 falls back to the generic decode
  assign sty = config_strap_pins[3:2];
  assign rd_dec = cmd_data_select && (sty == 2'h1 ? rd_n && wr_n :
                  sty == 2'h2 ? rd_n && !low_byte_strobe_n : !rd_n && wr_n);
  // Saturates so a long idle never wraps back into the read window
  assign quiet_nxt = rd_dec ? 3'h0 : (quiet_r == 3'h7 ? 3'h7 : quiet_r + 3'h1);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      quiet_r <= 3'h0;
    else
      quiet_r <= quiet_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence low5(s);
    !s [*5] ##1 s;
  endsequence
  sequence high5(s);
    s [*5] ##1 !s;
  endsequence

  no_bus_fight_a: assert property (
    host_d_oe_n || dev_d_oe_n) else $error("both ends drive the data bus");
  gen_strobe_excl_a: assert property (
    sty != 2'h1 && sty != 2'h2 |-> rd_n || wr_n) else $error("read and write strobes low together");
  gen_write_len_a: assert property (
    sty == 2'h0 && $fell(wr_n) |-> low5(wr_n)) else $error("generic write strobe length wrong");
  en_strobe_len_a: assert property (
    sty == 2'h1 && $rose(wr_n) |-> high5(wr_n)) else $error("enable strobe length wrong");
  lds_strobe_len_a: assert property (
    sty == 2'h2 && $fell(low_byte_strobe_n) |-> low5(low_byte_strobe_n)) else $error("lower strobe length wrong");
  write_held_a: assert property (
    sty == 2'h0 && !wr_n && $past(!wr_n) |-> $stable(host_d_o) && $stable(cmd_data_select) && !host_d_oe_n)
    else $error("write data or select moved in strobe");
  gen_read_sel_a: assert property (
    sty == 2'h0 && !rd_n |-> cmd_data_select && host_d_oe_n) else $error("generic read without select");
  en_read_sel_a: assert property (
    sty == 2'h1 && rd_n && wr_n |-> cmd_data_select && host_d_oe_n) else $error("enable read without select");
  read_drive_a: assert property (
    rd_dec && !$past(rd_dec) |-> ##[1:4] !dev_d_oe_n) else $error("device did not answer read");
  idle_release_a: assert property (
    quiet_r >= 3'h5 |-> dev_d_oe_n) else $error("device drives bus without read");
endmodule : hbp_monitor

/* dv/host_bus_command_port_test.sv */
// Self-checking bench joining host end and device end
`timescale 1ns/10ps
module host_bus_command_port_test;
  logic        clk_i, rst_i, req_valid_i, req_ready_o, rsp_valid_o, stall;
  logic        font_rom_off_i, tall_font_i, use_font_ram_o, one_bpp_only_o;
  logic        cursor_dir_right_o, wr_valid_o, wr_ready_i;
  logic [1:0]  style_i, req_op_i;
  logic [7:0]  req_data_i, rsp_data_o, char_code_i, wr_data_o;
  logic [3:0]  row_sel_i;
  logic [15:0] font_fetch_addr_o, font_base_o, cursor_o, wr_addr_o;
  logic [23:0] wq[$];
  logic [7:0]  rq[$];
  int          fails, compares, cycles;

  hbp_if bus();
  hbp_host i_hbp_host(.clk_i(clk_i), .rst_i(rst_i), .bus(bus.host), .style_i(style_i),
    .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_data_i(req_data_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
  hbp_dev i_hbp_dev(.clk_i(clk_i), .rst_i(rst_i), .bus(bus.dev), .font_rom_off_i(font_rom_off_i),
    .tall_font_i(tall_font_i), .char_code_i(char_code_i), .row_sel_i(row_sel_i),
    .use_font_ram_o(use_font_ram_o), .font_fetch_addr_o(font_fetch_addr_o), .one_bpp_only_o(one_bpp_only_o),
    .font_base_o(font_base_o), .cursor_o(cursor_o), .cursor_dir_right_o(cursor_dir_right_o),
    .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i));
  hbp_monitor i_hbp_monitor(.clk_i(clk_i), .rst_i(rst_i), .cmd_data_select(bus.cmd_data_select),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .low_byte_strobe_n(bus.low_byte_strobe_n),
    .config_strap_pins(bus.config_strap_pins), .host_d_o(bus.host_d_o), .host_d_oe_n(bus.host_d_oe_n),
    .dev_d_oe_n(bus.dev_d_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [23:0] e, input logic [23:0] s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  // Holds the request until the host takes it, then leaves room for the device
  task automatic send(input logic [1:0] op, input logic [7:0] d);
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_op_i = op;
    req_data_i = d;
    // Ready is looked at on the falling edge, where it has settled
    while (req_ready_o !== 1'b1)
      @(negedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    repeat (12) @(negedge clk_i);
  endtask : send

  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // A stalled receiver must not lose words already buffered
  always @(negedge clk_i)
    wr_ready_i <= stall ? 1'b0 : 1'($urandom);

  always @(posedge clk_i)
  begin
    if (!rst_i && wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
      chk("write", wq.size() ? wq.pop_front() : 24'hxxxxxx, {wr_addr_o, wr_data_o});
    if (rsp_valid_o === 1'b1)
      chk("read", {16'h0, rq.size() ? rq.pop_front() : 8'hxx}, {16'h0, rsp_data_o});
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    logic [7:0] b;
    logic       use_e;
    logic [15:0] addr_e;
    logic [15:0] base_e;
    {rst_i, req_valid_i, req_op_i, req_data_i, stall, wr_ready_i, style_i} = '0;
    {font_rom_off_i, tall_font_i, char_code_i, row_sel_i} = '0;
    rst_i = 1'b1;
    void'($urandom(39005));
    for (int s = 0; s < 3; s++)
    begin
      style_i = s[1:0];
      rst_i = 1'b1;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("dir_reset", 24'h0, {23'h0, cursor_dir_right_o});
      chk("base_reset", 24'h0, {8'h0, font_base_o});
      send(2'h3, 8'h5c);
      send(2'h2, 8'h00);
      send(2'h2, 8'h40);
      chk("font_base", 24'h004000, {8'h0, font_base_o});
      send(2'h3, 8'h4c);
      chk("dir", 24'h1, {23'h0, cursor_dir_right_o});
      send(2'h3, 8'h46);
      send(2'h2, 8'h00);
      send(2'h2, 8'h48);
      chk("cursor", 24'h004800, {8'h0, cursor_o});
      send(2'h3, 8'h42);
      // Last three bytes meet a stalled receiver: two fill the buffer, one is refused
      for (int i = 0; i < 7; i++)
      begin
        b = 8'($urandom);
        // Stall only once the buffer is empty, so exactly two words fit
        if (i == 4)
          while (wq.size() != 0)
            @(negedge clk_i);
        stall = (i > 3);
        if (i < 6)
          wq.push_back({16'(16'h4800 + i), b});
        send(2'h2, b);
      end
      chk("cursor_adv", 24'h004806, {8'h0, cursor_o});
      stall = 1'b0;
      repeat (20) @(negedge clk_i);
      chk("drained", 24'h0, 24'(wq.size()));
      send(2'h3, 8'h47);
      rq.push_back(8'h06);
      send(2'h1, 8'h00);
      chk("read_done", 24'h0, 24'(rq.size()));
      base_e = 16'h4000;
      for (int j = 0; j < 16; j++)
      begin
        // Without the font ROM the base must be zero
        if (j == 8)
        begin
          send(2'h3, 8'h5c);
          send(2'h2, 8'h00);
          send(2'h2, 8'h00);
          base_e = 16'h0000;
        end
        @(negedge clk_i);
        font_rom_off_i = (j >= 8);
        tall_font_i = 1'($urandom);
        char_code_i = 8'($urandom);
        row_sel_i = tall_font_i ? 4'($urandom) : 4'($urandom % 8);
        #1;
        use_e = font_rom_off_i || (char_code_i >= 8'h80 && char_code_i <= 8'h9f) || char_code_i >= 8'he0;
        addr_e = base_e + (tall_font_i ? {4'h0, char_code_i, 4'h0} : {5'h0, char_code_i, 3'h0}) + row_sel_i;
        chk("font", {6'h0, use_e, use_e, addr_e}, {6'h0, use_font_ram_o, one_bpp_only_o, font_fetch_addr_o});
      end
      repeat (10) @(negedge clk_i);
      $display("test style %0d done", s);
    end
    give_verdict();
  end
endmodule : host_bus_command_port_test
